// [sim/cct_device_model.sv]
`default_nettype none
// Far side: returns one whole completion per admitted request
module cct_device_model
  import cct_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic req_valid,
  input wire np_req_t req,
  input wire logic req_ready,
  input wire logic rx_ready,
  output logic cpl_valid = 1'b0,
  output cpl_hdr_t cpl = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  np_req_t pend_q[$];
  np_req_t head;
  // Records each request that the tracker let through
  always @(posedge clk)
  begin
    if (req_valid && req_ready)
      pend_q.push_back(req);
  end
  always @(negedge clk)
  begin
    cpl_valid <= 1'b0;
    cpl <= ~cpl; // Idle header lines keep changing
    if (go && rx_ready && pend_q.size() > 0)
    begin
      head = pend_q.pop_front();
      cpl_valid <= 1'b1;
      cpl <= '{head.start_addr[6:0], head.size_bytes, head.tag, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [sim/completion_credit_tracker_tb.sv]
`default_nettype none
module completion_credit_tracker_tb
  import cct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RCB = DEF_BOUNDARY_BYTES;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  np_req_t req = '0;
  logic req_ready;
  logic go = 1'b0;
  logic cpl_valid;
  cpl_hdr_t cpl;
  logic rx_ready;
  logic [HDR_W-1:0] hdr_out;
  logic [DATA_W-1:0] data_out;
  logic req_ready_b;
  logic rx_ready_b;
  logic [HDR_W-1:0] hdr_out_b;
  logic [DATA_W-1:0] data_out_b;
  int miscompares = 0;
  int n_tests = 0;
  int exp_h = 0;
  int exp_d = 0;
  int hn_q[$];
  int dn_q[$];
  int corner_a [3] = '{32'h7c, 32'h0, 32'h3f};
  int corner_s [3] = '{32'h8, 32'h4d0, 32'h1};

  // Header need of one request
  function automatic int hneed(int a, int s);
    return ((a % RCB) + s + RCB - 1) / RCB;
  endfunction
  // Data need, nothing for an I/O write
  function automatic int dneed(int a, int s, req_kind_t k);
    if (k == kind_io_write)
      return 0;
    return ((a % 16) + s + 15) / 16;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Free-running 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  completion_credit_tracker #(
    .METHOD(per_request_release),
    .BOUNDARY_BYTES(RCB),
    .HDR_TOTAL(DEF_HDR_TOTAL),
    .DATA_TOTAL(DEF_DATA_TOTAL),
    .DATA_SCALE(1)
  ) u_dut (
    .clk(clk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .cpl_valid(cpl_valid),
    .cpl(cpl),
    .rx_ready(rx_ready),
    .hdr_credits_outstanding(hdr_out),
    .data_credits_outstanding(data_out)
  );

  // Same traffic through the per-data-credit method
  completion_credit_tracker #(
    .METHOD(per_data_credit_release),
    .BOUNDARY_BYTES(RCB),
    .HDR_TOTAL(DEF_HDR_TOTAL),
    .DATA_TOTAL(DEF_DATA_TOTAL),
    .DATA_SCALE(1)
  ) u_dut_dc (
    .clk(clk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready_b),
    .cpl_valid(cpl_valid),
    .cpl(cpl),
    .rx_ready(rx_ready_b),
    .hdr_credits_outstanding(hdr_out_b),
    .data_credits_outstanding(data_out_b)
  );

  cct_device_model u_dev (
    .clk(clk),
    .go(go),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .rx_ready(rx_ready),
    .cpl_valid(cpl_valid),
    .cpl(cpl)
  );

  // Random traffic with corner requests first, then a full drain
  initial
  begin
    int a;
    int s;
    int h;
    int d;
    int n;
    logic fit;
    logic cpl_now;
    logic drain;
    req_kind_t k;
    n = 0;
    void'($urandom(30894));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    check("hdr reset", 32'(hdr_out), 32'h0);
    check("data reset", 32'(data_out), 32'h0);
    check("dc hdr reset", 32'(hdr_out_b), 32'h0);
    check("dc data reset", 32'(data_out_b), 32'h0);
    for (int i = 0; i < 440; i++)
    begin
      drain = i >= 400;
      cpl_now = hn_q.size() > 0 &&
        (drain || hn_q.size() >= 20 || $urandom % 3 == 0);
      go <= cpl_now;
      @(negedge clk);
      go <= 1'b0;
      k = req_kind_t'($urandom % 3);
      a = int'($urandom % 4096);
      s = 1 + int'($urandom % ((k == kind_mem_read) ? 700 : 4));
      if (i < 3)
      begin
        a = corner_a[i];
        s = corner_s[i];
        k = kind_mem_read;
      end
      h = hneed(a, s);
      d = dneed(a, s, k);
      fit = !drain && exp_h + h <= DEF_HDR_TOTAL &&
        exp_d + d <= DEF_DATA_TOTAL;
      req_valid <= !drain;
      req <= '{12'(a), 13'(s), k, 5'(n)};
      #1;
      check("req_ready", 32'(req_ready), 32'(fit));
      check("dc req_ready", 32'(req_ready_b), 32'(fit));
      check("rx_ready", 32'(rx_ready), 32'h1);
      check("dc rx_ready", 32'(rx_ready_b), 32'h1);
      if (fit)
      begin
        hn_q.push_back(h);
        dn_q.push_back(d);
        exp_h += h;
        exp_d += d;
        n++;
      end
      if (cpl_now)
      begin
        exp_h -= hn_q.pop_front();
        exp_d -= dn_q.pop_front();
      end
      @(negedge clk);
      req_valid <= 1'b0;
      #1;
      check("hdr", 32'(hdr_out), 32'(exp_h));
      check("data", 32'(data_out), 32'(exp_d));
      check("dc hdr", 32'(hdr_out_b), 32'(exp_h));
      check("dc data", 32'(data_out_b), 32'(exp_d));
    end
    check("drained", 32'(hn_q.size()), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire

// [src/cct_need_calc.sv]
`default_nettype none
// Worst-case credits of one non-posted request
module cct_need_calc
  import cct_pkg::*;
#(
  parameter int unsigned BOUNDARY_BYTES = DEF_BOUNDARY_BYTES,
  parameter method_t METHOD = per_request_release,
  parameter int unsigned DATA_SCALE = 1
)(
  input wire np_req_t req,
  output logic [HDR_W-1:0] req_hdr_credit_need,
  output logic [DATA_W-1:0] req_data_credit_need
);
  localparam int unsigned BND_LOG2 = $clog2(BOUNDARY_BYTES);
  localparam int unsigned UNIT_LOG2 = $clog2(CREDIT_BYTES / DATA_SCALE);
  logic [13:0] hdr_span;
  logic [13:0] data_span;

  // Need arithmetic
  always_comb
  begin
    // R02: header need
    hdr_span = span_count(req.start_addr, req.size_bytes, BND_LOG2);
    req_hdr_credit_need = hdr_span[HDR_W-1:0];
    // R03: data need rounded up, R17 scaled unit
    data_span = span_count(req.start_addr, req.size_bytes, UNIT_LOG2);
    req_data_credit_need = data_span[DATA_W-1:0];
    // R04: I/O write needs no data; R15 I/O read one credit in per-boundary method only
    if (req.kind == kind_io_write)
      req_data_credit_need = DATA_RESET;
    else if (req.kind == kind_io_read && METHOD == per_boundary_release)
      req_data_credit_need = 12'(DATA_SCALE);
  end
endmodule
`default_nettype wire

// [src/cct_pkg.sv]
// Behaviour
// R01: Header and data counters cleared at reset.
// R02: Header need from address, size, boundary.
// R03: Data need in 16-byte credits, rounded up.
// R04: I/O write needs no data credits.
// R05: Admit only when both totals hold.
// R06: Add needs to counters on send.
// R07: Per-request method stores needs by tag.
// R08: Per-request release after final completion data.
// R09: Data credits per boundary is boundary/16.
// R10: Header release per completion start and crossing.
// R11: Per-boundary method releases data per header.
// R12: Crossings from lower address and length.
// R13: Running address alternative counts rollovers.
// R14: Per-data-credit method releases per 16-byte crossing.
// R15: I/O read one credit, write none. Code gives I/O read one credit in the per-boundary method only.
// R16: Completions matched to request type by tag.
// R17: Data total scalable by two or four.
// R18: Streaming needs receive ready held high.
// R19: Device never overflows with ready held.
// R20: Boundary defaults to 64 bytes.
// R21: Static configuration, counters saturate at zero.
// R22: Ready asserted only when admission passes.
`default_nettype none
package cct_pkg;
  localparam int unsigned CREDIT_BYTES = 16;
  // R20: default boundary of 64 bytes
  localparam int unsigned DEF_BOUNDARY_BYTES = 64;
  localparam int unsigned DEF_HDR_TOTAL = 36;
  localparam int unsigned DEF_DATA_TOTAL = 77;
  localparam int unsigned HDR_W = 8;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned TAG_W = 5;
  localparam logic [HDR_W-1:0] HDR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;

  typedef enum logic [3:0] {
    per_request_release = 4'h1,
    per_boundary_release = 4'h2,
    per_data_credit_release = 4'h4,
    line_rate_streaming = 4'h8
  } method_t;

  typedef enum logic [1:0] {
    kind_mem_read = 2'h0,
    kind_io_read = 2'h1,
    kind_io_write = 2'h2
  } req_kind_t;

  typedef struct packed {
    logic [11:0] start_addr;
    logic [12:0] size_bytes;
    req_kind_t kind;
    logic [TAG_W-1:0] tag;
  } np_req_t;

  typedef struct packed {
    logic [6:0] lower_addr;
    logic [12:0] length_bytes;
    logic [TAG_W-1:0] tag;
    logic last;
  } cpl_hdr_t;

  // Ceiling of (addr mod unit + len) / unit, unit a power of two
  function automatic logic [13:0] span_count(input logic [11:0] addr,
    input logic [12:0] len, input int unsigned unit_log2);
    logic [13:0] sum;
    logic [13:0] mask;
    sum = 14'h0000;
    mask = 14'((1 << unit_log2) - 1);
    sum = ({2'h0, addr} & mask) + {1'b0, len} + mask;
    span_count = sum >> unit_log2;
  endfunction
endpackage
`default_nettype wire

// [src/cct_release_calc.sv]
`default_nettype none
// Credits freed by one completion
module cct_release_calc
  import cct_pkg::*;
#(
  parameter int unsigned BOUNDARY_BYTES = DEF_BOUNDARY_BYTES,
  parameter int unsigned DATA_SCALE = 1
)(
  input wire cpl_hdr_t cpl,
  output logic [HDR_W-1:0] boundary_crossings,
  output logic [DATA_W-1:0] data_credit_crossings
);
  localparam int unsigned BND_LOG2 = $clog2(BOUNDARY_BYTES);
  localparam int unsigned UNIT_LOG2 = $clog2(CREDIT_BYTES / DATA_SCALE);
  logic [13:0] bspan;
  logic [13:0] dspan;

  // Crossing counts from completion header
  always_comb
  begin
    // R13: ceiling formula replaces rollover counting
    // R12: boundary crossings
    bspan = span_count({5'h00, cpl.lower_addr}, cpl.length_bytes, BND_LOG2);
    boundary_crossings = bspan[HDR_W-1:0];
    // R14: data credit crossings
    dspan = span_count({5'h00, cpl.lower_addr}, cpl.length_bytes, UNIT_LOG2);
    data_credit_crossings = dspan[DATA_W-1:0];
  end
endmodule
`default_nettype wire

// [src/completion_credit_tracker.sv]
`default_nettype none
// Admission and release of completion credits
module completion_credit_tracker
  import cct_pkg::*;
#(
  parameter method_t METHOD = per_request_release,
  parameter int unsigned BOUNDARY_BYTES = DEF_BOUNDARY_BYTES,
  parameter int unsigned HDR_TOTAL = DEF_HDR_TOTAL,
  parameter int unsigned DATA_TOTAL = DEF_DATA_TOTAL,
  parameter int unsigned DATA_SCALE = 1
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire np_req_t req,
  output logic req_ready,
  input wire logic cpl_valid,
  input wire cpl_hdr_t cpl,
  output logic rx_ready,
  output logic [HDR_W-1:0] hdr_credits_outstanding,
  output logic [DATA_W-1:0] data_credits_outstanding
);
  // R21: static configuration; R17 scaled data total
  localparam logic [DATA_W:0] DATA_LIMIT =
    (DATA_W+1)'(DATA_TOTAL * DATA_SCALE);
  localparam logic [HDR_W:0] HDR_LIMIT = (HDR_W+1)'(HDR_TOTAL);
  // R09: data credits per boundary
  localparam logic [DATA_W-1:0] data_credits_per_boundary =
    DATA_W'(BOUNDARY_BYTES / CREDIT_BYTES * DATA_SCALE);
  localparam int unsigned NTAG = 1 << TAG_W;

  logic [HDR_W-1:0] hdr_q;
  logic [HDR_W-1:0] hdr_d;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  logic [HDR_W-1:0] req_hdr_credit_need;
  logic [DATA_W-1:0] req_data_credit_need;
  logic [HDR_W-1:0] boundary_crossings;
  logic [DATA_W-1:0] data_credit_crossings;
  logic [HDR_W-1:0] hdr_store_q [NTAG];
  logic [DATA_W-1:0] data_store_q [NTAG];
  req_kind_t kind_store_q [NTAG];
  logic admit;
  logic send;
  logic [HDR_W-1:0] hdr_add;
  logic [DATA_W-1:0] data_add;
  logic [HDR_W-1:0] hdr_sub;
  logic [DATA_W-1:0] data_sub;
  logic [HDR_W:0] hdr_tmp;
  logic [DATA_W:0] data_tmp;
  logic [DATA_W+HDR_W-1:0] prod;

  cct_need_calc #(
    .BOUNDARY_BYTES(BOUNDARY_BYTES),
    .METHOD(METHOD),
    .DATA_SCALE(DATA_SCALE)
  ) u_need (
    .req(req),
    .req_hdr_credit_need(req_hdr_credit_need),
    .req_data_credit_need(req_data_credit_need)
  );

  cct_release_calc #(
    .BOUNDARY_BYTES(BOUNDARY_BYTES),
    .DATA_SCALE(DATA_SCALE)
  ) u_rel (
    .cpl(cpl),
    .boundary_crossings(boundary_crossings),
    .data_credit_crossings(data_credit_crossings)
  );

  // Admission check
  always_comb
  begin
    // R05: both totals must hold; streaming relies on R18
    admit = ({1'b0, hdr_q} + {1'b0, req_hdr_credit_need} <= HDR_LIMIT) &&
            ({1'b0, data_q} + {1'b0, req_data_credit_need} <= DATA_LIMIT);
    if (METHOD == line_rate_streaming)
      admit = 1'b1;
  end

  // R22: ready only with a passing request
  assign req_ready = req_valid && admit;
  assign send = req_ready;
  // R18: completions always taken at line rate (R19 on far side)
  assign rx_ready = 1'b1;
  assign hdr_credits_outstanding = hdr_q;
  assign data_credits_outstanding = data_q;

  // Release amounts per method
  always_comb
  begin
    hdr_sub = HDR_RESET;
    data_sub = DATA_RESET;
    prod = '0;
    if (cpl_valid)
    begin
      case (METHOD)
        per_request_release:
        begin
          // R08: release stored needs on final completion
          if (cpl.last)
          begin
            hdr_sub = hdr_store_q[cpl.tag];
            data_sub = data_store_q[cpl.tag];
          end
        end
        per_boundary_release:
        begin
          // R10: one header per completion start and per crossing
          hdr_sub = boundary_crossings;
          // R11: boundary data per header; R16 tag-matched I/O policy
          prod = boundary_crossings * data_credits_per_boundary;
          data_sub = prod[DATA_W-1:0];
          if (kind_store_q[cpl.tag] == kind_io_read)
            data_sub = DATA_W'(DATA_SCALE);
          else if (kind_store_q[cpl.tag] == kind_io_write)
            data_sub = DATA_RESET;
        end
        per_data_credit_release:
        begin
          // R10: header release; R14 data crossings
          hdr_sub = boundary_crossings;
          data_sub = data_credit_crossings;
          if (kind_store_q[cpl.tag] == kind_io_write)
            data_sub = DATA_RESET;
        end
        default:
        begin
          hdr_sub = HDR_RESET;
          data_sub = DATA_RESET;
        end
      endcase
    end
  end

  // Next counter values
  always_comb
  begin
    hdr_add = send ? req_hdr_credit_need : HDR_RESET;
    data_add = send ? req_data_credit_need : DATA_RESET;
    // R06: add needs on send
    hdr_tmp = {1'b0, hdr_q} + {1'b0, hdr_add};
    data_tmp = {1'b0, data_q} + {1'b0, data_add};
    // R21: saturate at zero
    hdr_d = (hdr_tmp > {1'b0, hdr_sub}) ?
            HDR_W'(hdr_tmp - {1'b0, hdr_sub}) : HDR_RESET;
    data_d = (data_tmp > {1'b0, data_sub}) ?
             DATA_W'(data_tmp - {1'b0, data_sub}) : DATA_RESET;
    if (METHOD == line_rate_streaming)
    begin
      hdr_d = HDR_RESET;
      data_d = DATA_RESET;
    end
  end

  // Outstanding counters
  // R01: cleared at reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hdr_q <= HDR_RESET;
      data_q <= DATA_RESET;
    end
    else
    begin
      hdr_q <= hdr_d;
      data_q <= data_d;
    end
  end

  // Per-tag store of needs and kind
  // R07: keep needs per sent request
  always_ff @(posedge clk)
  begin
    if (send)
    begin
      hdr_store_q[req.tag] <= req_hdr_credit_need;
      data_store_q[req.tag] <= req_data_credit_need;
      kind_store_q[req.tag] <= req.kind;
    end
  end

  // Admission never overruns totals
  // R05: counters bounded
  hdr_bound_a: assert property (@(posedge clk) disable iff (!nrst) // R05
    ({1'b0, hdr_q} <= HDR_LIMIT) && ({1'b0, data_q} <= DATA_LIMIT))
    else $error("outstanding credits above total");

  ready_admit_a: assert property (@(posedge clk) disable iff (!nrst) // R22
    req_ready |-> (METHOD == line_rate_streaming) ||
      ({1'b0, hdr_q} + {1'b0, req_hdr_credit_need} <= HDR_LIMIT))
    else $error("ready without header room");

  send_add_a: assert property (@(posedge clk) disable iff (!nrst) // R06
    (send && !cpl_valid && METHOD != line_rate_streaming) |=>
      hdr_q == $past(hdr_q) + $past(req_hdr_credit_need))
    else $error("header need not added on send");

  reset_clear_a: assert property (@(posedge clk) // R01
    $rose(nrst) |-> hdr_q == HDR_RESET && data_q == DATA_RESET)
    else $error("counters not clear after reset");

  rx_ready_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    rx_ready[*2])
    else $error("receive ready dropped");

  io_write_a: assert property (@(posedge clk) disable iff (!nrst) // R04
    (req_valid && req.kind == kind_io_write) |->
      req_data_credit_need == DATA_RESET)
    else $error("io write asks data credits");

  release_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R08
    (METHOD == per_request_release && !send && cpl_valid && !cpl.last) |=>
      hdr_q == $past(hdr_q))
    else $error("early per-request release");

  sat_zero_a: assert property (@(posedge clk) disable iff (!nrst) // R21
    (!send && cpl_valid && hdr_sub >= hdr_q) |=> hdr_q == HDR_RESET)
    else $error("header counter did not saturate");

  // Data admission
  data_admit_a: assert property (@(posedge clk) disable iff (!nrst) // R05
    req_ready |-> (METHOD == line_rate_streaming) ||
      ({1'b0, data_q} + {1'b0, req_data_credit_need} <= DATA_LIMIT))
    else $error("ready without data room");

  // Refusal when header room is short
  hdr_refuse_a: assert property (@(posedge clk) disable iff (!nrst) // R05
    (req_valid && METHOD != line_rate_streaming &&
      ({1'b0, hdr_q} + {1'b0, req_hdr_credit_need} > HDR_LIMIT)) |->
      !req_ready)
    else $error("ready despite header shortage");

  // Ready never without a request
  ready_valid_a: assert property (@(posedge clk) disable iff (!nrst) // R22
    req_ready |-> req_valid)
    else $error("ready without valid");

  // Data need added on send
  data_add_a: assert property (@(posedge clk) disable iff (!nrst) // R06
    (send && !cpl_valid && METHOD != line_rate_streaming) |=>
      data_q == $past(data_q) + $past(req_data_credit_need))
    else $error("data need not added on send");

  // Counters hold while idle
  idle_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R21
    (!send && !cpl_valid) |=>
      hdr_q == $past(hdr_q) && data_q == $past(data_q))
    else $error("counters moved while idle");

  // Data held until the final completion
  data_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R08
    (METHOD == per_request_release && !send && cpl_valid && !cpl.last)
      |=> data_q == $past(data_q))
    else $error("early per-request data release");

  // Stored needs match the sent request
  store_keep_a: assert property (@(posedge clk) disable iff (!nrst) // R07
    send |=> hdr_store_q[$past(req.tag)] == $past(req_hdr_credit_need) &&
      data_store_q[$past(req.tag)] == $past(req_data_credit_need))
    else $error("stored needs lost");

  // Header release per completion start and crossing
  hdr_cross_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    (cpl_valid && (METHOD == per_boundary_release ||
      METHOD == per_data_credit_release)) |-> hdr_sub == boundary_crossings)
    else $error("header release not per crossing");

  // Data release per 16-byte crossing
  data_cross_a: assert property (@(posedge clk) disable iff (!nrst) // R14
    (cpl_valid && METHOD == per_data_credit_release &&
      kind_store_q[cpl.tag] != kind_io_write) |->
      data_sub == data_credit_crossings)
    else $error("data release not per credit");

  // Boundary data release per header
  bnd_data_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    (cpl_valid && METHOD == per_boundary_release &&
      kind_store_q[cpl.tag] == kind_mem_read) |->
      data_sub == DATA_W'(boundary_crossings * data_credits_per_boundary))
    else $error("boundary data release wrong");

  // One data credit per I/O read
  io_read_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    (req_valid && req.kind == kind_io_read &&
      METHOD == per_boundary_release) |->
      req_data_credit_need == DATA_W'(DATA_SCALE))
    else $error("io read need not one credit");

  // Streaming leaves counters at zero
  stream_zero_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    (METHOD == line_rate_streaming) |->
      hdr_q == HDR_RESET && data_q == DATA_RESET)
    else $error("streaming counters moved");

  // Data counter saturates at zero
  sat_data_a: assert property (@(posedge clk) disable iff (!nrst) // R21
    (!send && cpl_valid && data_sub >= data_q) |=> data_q == DATA_RESET)
    else $error("data counter did not saturate");

  // Header need covers any data
  hdr_need_a: assert property (@(posedge clk) disable iff (!nrst) // R02
    (req_valid && req.size_bytes != 13'h0000) |->
      req_hdr_credit_need != HDR_RESET)
    else $error("header need zero for data");
endmodule
`default_nettype wire
